/* File: inc/afersi_pkg.sv */
// Constants, types and register map of the receive-side converter interface
package afersi_pkg;

  // ==========================================================================
  // Bus shape
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ==========================================================================
  // Register byte addresses
  localparam logic [7:0] ADDR_IFACE_CTRL = 8'h00;
  localparam logic [7:0] ADDR_RX_CTRL    = 8'h04;
  localparam logic [7:0] ADDR_TX_CTRL0   = 8'h08;
  localparam logic [7:0] ADDR_CFG_WORD   = 8'h0c;

  // ==========================================================================
  // Field positions
  localparam int IC_EN_BIT    = 0;
  localparam int IC_MODE_LSB  = 3;
  localparam int RXC_LEN_LSB  = 0;
  localparam int RXC_POS_LSB  = 2;
  localparam int RXC_RES_LSB  = 8;

  // ==========================================================================
  // Reset values
  localparam logic [15:0] TX_CTRL0_RESET = 16'h0000;
  localparam logic [15:0] CFG_WORD_RESET = 16'h0000;
  localparam logic [15:0] RX_CTRL_RESET  = 16'h0000;

  // ==========================================================================
  // Receive mode codes
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_PDOWN  = 2'h1;
  localparam logic [1:0] MODE_CONFIG = 2'h2;

  // ==========================================================================
  // Frame and timing figures, in link clock cycles
  localparam int FRAME_BITS     = 16;
  localparam int PD_WAKE_CYCLES = 6;
  localparam int DATA_LEN_BASE  = 8;
  localparam int FILL_BITS_MAX  = 8;

  // ==========================================================================
  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Link state machine
  typedef enum logic [3:0] {
    LINK_IDLE   = 4'b0001,
    LINK_CONV   = 4'b0010,
    LINK_PDOWN  = 4'b0100,
    LINK_CONFIG = 4'b1000
  } afersi_link_state_type;

  // ==========================================================================
  // Carriers between domains
  typedef struct packed {
    logic        rx_enable;
    logic [1:0]  mode;
    logic [1:0]  len_code;
    logic [3:0]  lsb_pos;
    logic [15:0] config_word;
  } afersi_cfg_type;

  typedef struct packed {
    logic phy_request;
    logic serial_in;
  } afersi_pins_type;

  typedef struct packed {
    logic done_toggle;
    logic residual_toggle;
  } afersi_events_type;

endpackage

/* File: rtl/afersi_sync.sv */
// Two-flop synchroniser for levels and toggles
module afersi_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] held;
  } afersi_sync_state_type;

  afersi_sync_state_type r;
  afersi_sync_state_type next_r;

  // ==========================================================================
  // Next state
  always_comb begin
    next_r      = r;
    next_r.meta = d;
    next_r.held = r.meta;
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign q = r.held;

endmodule

/* File: rtl/afersi_top.sv */
// Receive-side serial converter interface with AXI4-Lite register access
// What this block does
// - Receive mode 00 normal, 01 power-down cycle, 10 active configuration.
// - Normal mode converts back to back when enabled and receive requested.
// - Conversions stop when request drops or software clears enable.
// - Power-down cycle raises converter enable after six link clock cycles.
// - Serial input from the converter is ignored during power-down.
// - Finished power-down cycle rewrites the mode field to normal.
// - Power-down runs even with receive disabled, then returns to idle.
// - Configuration mode shifts the config word out on the serial output.
// - Fill bits around the data word land in bits 8 to 15.
// - Unoccupied residual positions read as zero.
// - Residual keeps arrival order, last fill bit in bit 8.
// - Transmit control register 0 clears to zero on reset.
module afersi_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        interface_receive_clock,
  input  wire logic        phy_receive_request,
  input  wire logic        converter_serial_in,
  output logic             converter_serial_out,
  output logic             converter_receive_enable_out
);

  localparam logic [4:0] FRAME_LAST =
    5'(afersi_pkg::FRAME_BITS - 1);
  localparam logic [4:0] PD_LAST =
    5'(afersi_pkg::PD_WAKE_CYCLES - 1);

  // ==========================================================================
  // Bus-side state
  typedef struct packed {
    logic        aw_full;
    logic [7:0]  aw_addr;
    logic        w_full;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rx_enable;
    logic [1:0]  mode;
    logic [1:0]  len_code;
    logic [3:0]  lsb_pos;
    logic [15:0] tx_ctrl0;
    logic [15:0] cfg_word;
    logic [7:0]  residual;
    logic        done_seen;
    logic        resid_seen;
  } afersi_bus_state_type;

  // ==========================================================================
  // Link-side state
  typedef struct packed {
    afersi_pkg::afersi_link_state_type state;
    logic [4:0]  cnt;
    logic [15:0] sdo_sh;
    logic [15:0] rx_sh;
    logic [1:0]  end_pipe;
    logic        rxen;
    logic        sdo;
    logic        pd_hold;
    logic        cfg_sent;
    logic [7:0]  resid;
    logic        resid_tgl;
    logic        done_tgl;
  } afersi_link_state_type_regs_type;

  afersi_bus_state_type            r;
  afersi_bus_state_type            next_r;
  afersi_link_state_type_regs_type l;
  afersi_link_state_type_regs_type next_l;

  afersi_pkg::afersi_cfg_type    cfg_bus;
  afersi_pkg::afersi_cfg_type    cfg_s;
  afersi_pkg::afersi_pins_type   pins_raw;
  afersi_pkg::afersi_pins_type   pins_s;
  afersi_pkg::afersi_events_type ev_link;
  afersi_pkg::afersi_events_type ev_s;
  logic                          link_resetn;

  // ==========================================================================
  // Helpers
  function automatic logic [15:0] merge16(
    input logic [15:0] old,
    input logic [31:0] data,
    input logic [3:0]  strb
  );
    logic [15:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction

  // Compacts non-data bits of a frame, earliest bit highest
  function automatic logic [7:0] extract_fill(
    input logic [15:0] frame,
    input logic [1:0]  len_code,
    input logic [3:0]  lsb_pos
  );
    logic [7:0] res;
    logic [5:0] lo;
    logic [5:0] hi;
    res = '0;
    lo  = {2'h0, lsb_pos};
    hi  = lo + 6'(afersi_pkg::DATA_LEN_BASE) + {3'h0, len_code, 1'b0};
    for (int i = afersi_pkg::FRAME_BITS - 1; i >= 0; i--) begin
      if (6'(i) < lo || 6'(i) >= hi) begin
        res = {res[6:0], frame[i]};
      end
    end
    return res;
  endfunction

  // ==========================================================================
  // Domain crossings
  assign cfg_bus = '{
    rx_enable:   r.rx_enable,
    mode:        r.mode,
    len_code:    r.len_code,
    lsb_pos:     r.lsb_pos,
    config_word: r.cfg_word
  };
  assign pins_raw = '{
    phy_request: phy_receive_request,
    serial_in:   converter_serial_in
  };
  assign ev_link = '{
    done_toggle:     l.done_tgl,
    residual_toggle: l.resid_tgl
  };

  afersi_sync #(.WIDTH(1)) u_link_reset (
    .clk    (interface_receive_clock),
    .resetn (1'b1),
    .d      (aresetn),
    .q      (link_resetn)
  );

  afersi_sync #(.WIDTH($bits(afersi_pkg::afersi_cfg_type))) u_cfg_sync (
    .clk    (interface_receive_clock),
    .resetn (link_resetn),
    .d      (cfg_bus),
    .q      (cfg_s)
  );

  afersi_sync #(.WIDTH($bits(afersi_pkg::afersi_pins_type))) u_pin_sync (
    .clk    (interface_receive_clock),
    .resetn (link_resetn),
    .d      (pins_raw),
    .q      (pins_s)
  );

  afersi_sync #(.WIDTH($bits(afersi_pkg::afersi_events_type))) u_ev_sync (
    .clk    (aclk),
    .resetn (aresetn),
    .d      (ev_link),
    .q      (ev_s)
  );

  // ==========================================================================
  // Bus side next state
  always_comb begin
    next_r = r;
    if (awvalid && r.awready) begin
      next_r.aw_full = 1'b1;
      next_r.aw_addr = awaddr;
    end
    if (wvalid && r.wready) begin
      next_r.w_full = 1'b1;
      next_r.w_data = wdata;
      next_r.w_strb = wstrb;
    end
    if (r.bvalid && bready) begin
      next_r.bvalid = 1'b0;
    end
    // Power-down completion from the link
    if (ev_s.done_toggle != r.done_seen) begin
      next_r.done_seen = ev_s.done_toggle;
      if (r.mode == afersi_pkg::MODE_PDOWN) begin
        next_r.mode = afersi_pkg::MODE_NORMAL;
      end
    end
    // Residual of a completed frame
    if (ev_s.residual_toggle != r.resid_seen) begin
      next_r.resid_seen = ev_s.residual_toggle;
      next_r.residual   = l.resid;
    end
    // Register write
    if (r.aw_full && r.w_full && !r.bvalid) begin
      next_r.aw_full = 1'b0;
      next_r.w_full  = 1'b0;
      next_r.bvalid  = 1'b1;
      next_r.bresp   = afersi_pkg::RESP_OKAY;
      case ({r.aw_addr[7:2], 2'b00})
        afersi_pkg::ADDR_IFACE_CTRL: begin
          if (r.w_strb[0]) begin
            next_r.rx_enable = r.w_data[afersi_pkg::IC_EN_BIT];
            next_r.mode = r.w_data[afersi_pkg::IC_MODE_LSB +: 2];
          end
        end
        afersi_pkg::ADDR_RX_CTRL: begin
          if (r.w_strb[0]) begin
            next_r.len_code = r.w_data[afersi_pkg::RXC_LEN_LSB +: 2];
            next_r.lsb_pos  = r.w_data[afersi_pkg::RXC_POS_LSB +: 4];
          end
        end
        afersi_pkg::ADDR_TX_CTRL0: begin
          next_r.tx_ctrl0 = merge16(r.tx_ctrl0, r.w_data, r.w_strb);
        end
        afersi_pkg::ADDR_CFG_WORD: begin
          next_r.cfg_word = merge16(r.cfg_word, r.w_data, r.w_strb);
        end
        default: begin
          next_r.bresp = afersi_pkg::RESP_SLVERR;
        end
      endcase
    end
    // Register read
    if (r.rvalid && rready) begin
      next_r.rvalid = 1'b0;
    end
    if (arvalid && r.arready) begin
      next_r.rvalid = 1'b1;
      next_r.rresp  = afersi_pkg::RESP_OKAY;
      next_r.rdata  = '0;
      case ({araddr[7:2], 2'b00})
        afersi_pkg::ADDR_IFACE_CTRL: begin
          next_r.rdata[afersi_pkg::IC_EN_BIT] = r.rx_enable;
          next_r.rdata[afersi_pkg::IC_MODE_LSB +: 2] = r.mode;
        end
        afersi_pkg::ADDR_RX_CTRL: begin
          next_r.rdata[afersi_pkg::RXC_LEN_LSB +: 2] = r.len_code;
          next_r.rdata[afersi_pkg::RXC_POS_LSB +: 4] = r.lsb_pos;
          next_r.rdata[afersi_pkg::RXC_RES_LSB +: 8] = r.residual;
        end
        afersi_pkg::ADDR_TX_CTRL0: begin
          next_r.rdata[15:0] = r.tx_ctrl0;
        end
        afersi_pkg::ADDR_CFG_WORD: begin
          next_r.rdata[15:0] = r.cfg_word;
        end
        default: begin
          next_r.rresp = afersi_pkg::RESP_SLVERR;
        end
      endcase
    end
    next_r.awready = !next_r.aw_full;
    next_r.wready  = !next_r.w_full;
    next_r.arready = !next_r.rvalid;
  end

  // ==========================================================================
  // Bus side registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r          <= '0;
      r.tx_ctrl0 <= afersi_pkg::TX_CTRL0_RESET;
      r.cfg_word <= afersi_pkg::CFG_WORD_RESET;
      r.mode     <= afersi_pkg::MODE_NORMAL;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================================
  // Link side next state
  always_comb begin
    next_l          = l;
    next_l.end_pipe = {l.end_pipe[0], 1'b0};
    // Shift samples during a frame and its pin-sync tail
    if (l.state == afersi_pkg::LINK_CONV || (|l.end_pipe)) begin
      next_l.rx_sh = {l.rx_sh[14:0], pins_s.serial_in};
    end
    if (l.end_pipe[1]) begin
      next_l.resid = extract_fill(next_l.rx_sh, cfg_s.len_code,
                                  cfg_s.lsb_pos);
      next_l.resid_tgl = ~l.resid_tgl;
    end
    if (cfg_s.mode != afersi_pkg::MODE_PDOWN) begin
      next_l.pd_hold = 1'b0;
    end
    if (cfg_s.mode != afersi_pkg::MODE_CONFIG) begin
      next_l.cfg_sent = 1'b0;
    end
    case (l.state)
      afersi_pkg::LINK_IDLE: begin
        next_l.rxen = 1'b1;
        next_l.sdo  = 1'b0;
        next_l.cnt  = '0;
        if (cfg_s.mode == afersi_pkg::MODE_PDOWN && !l.pd_hold) begin
          next_l.state = afersi_pkg::LINK_PDOWN;
          next_l.rxen  = 1'b0;
        end else if (cfg_s.mode == afersi_pkg::MODE_CONFIG &&
                     !l.cfg_sent) begin
          next_l.state  = afersi_pkg::LINK_CONFIG;
          next_l.sdo_sh = cfg_s.config_word;
        end else if (cfg_s.mode == afersi_pkg::MODE_NORMAL &&
                     cfg_s.rx_enable && pins_s.phy_request) begin
          next_l.state = afersi_pkg::LINK_CONV;
          next_l.rxen  = 1'b0;
        end
      end
      afersi_pkg::LINK_CONV: begin
        next_l.cnt = l.cnt + 5'h01;
        if (l.cnt == FRAME_LAST) begin
          next_l.cnt         = '0;
          next_l.end_pipe[0] = 1'b1;
          if (!(cfg_s.mode == afersi_pkg::MODE_NORMAL &&
                cfg_s.rx_enable && pins_s.phy_request)) begin
            next_l.state = afersi_pkg::LINK_IDLE;
            next_l.rxen  = 1'b1;
          end
        end
      end
      afersi_pkg::LINK_PDOWN: begin
        // No sampling here, serial input ignored
        next_l.cnt = l.cnt + 5'h01;
        if (l.cnt == PD_LAST) begin
          next_l.rxen     = 1'b1;
          next_l.pd_hold  = 1'b1;
          next_l.done_tgl = ~l.done_tgl;
          next_l.state    = afersi_pkg::LINK_IDLE;
        end
      end
      afersi_pkg::LINK_CONFIG: begin
        next_l.sdo    = l.sdo_sh[15];
        next_l.sdo_sh = {l.sdo_sh[14:0], 1'b0};
        next_l.cnt    = l.cnt + 5'h01;
        if (l.cnt == FRAME_LAST) begin
          next_l.cnt      = '0;
          next_l.cfg_sent = 1'b1;
          next_l.state    = afersi_pkg::LINK_IDLE;
        end
      end
      default: begin
        next_l.state = afersi_pkg::LINK_IDLE;
        next_l.rxen  = 1'b1;
      end
    endcase
  end

  // ==========================================================================
  // Link side registers
  always_ff @(posedge interface_receive_clock) begin
    if (!link_resetn) begin
      l       <= '0;
      l.state <= afersi_pkg::LINK_IDLE;
      l.rxen  <= 1'b1;
    end else begin
      l <= next_l;
    end
  end

  // ==========================================================================
  // Outputs
  assign awready                      = r.awready;
  assign wready                       = r.wready;
  assign bresp                        = r.bresp;
  assign bvalid                       = r.bvalid;
  assign arready                      = r.arready;
  assign rdata                        = r.rdata;
  assign rresp                        = r.rresp;
  assign rvalid                       = r.rvalid;
  assign converter_serial_out         = l.sdo;
  assign converter_receive_enable_out = l.rxen;

endmodule

/* File: verif/afersi_sva.sv */
// Concurrent checks on the converter interface top-level ports
module afersi_sva (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic        interface_receive_clock,
  input wire logic        phy_receive_request,
  input wire logic        converter_serial_out,
  input wire logic        converter_receive_enable_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====================
  // Enable-low run length
  logic [9:0] run;
  always_ff @(posedge interface_receive_clock) begin
    if (!aresetn || converter_receive_enable_out) begin
      run <= 10'h000;
    end else begin
      run <= run + 10'h001;
    end
  end

  sequence wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence

  sequence req_gone;
    !phy_receive_request [*4];
  endsequence

  // ====================
  // Register bus
  bvalid_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    bvalid && !bready |=> bvalid) else $error("bvalid dropped early");
  rvalid_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read answer not held");
  write_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_taken |-> ##2 bvalid) else $error("write answer late");
  read_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
    arvalid && arready |=> rvalid) else $error("read answer late");
  ar_blocked_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid |-> !arready) else $error("arready during read answer");
  slverr_data_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid && rresp == afersi_pkg::RESP_SLVERR |-> rdata == 32'h00000000)
    else $error("error read with data");

  // ====================
  // Link side
  low_run_a: assert property (@(posedge interface_receive_clock)
    disable iff (!aresetn)
    converter_receive_enable_out && run != 10'h000
    |-> run == 10'h006 || run[3:0] == 4'h0)
    else $error("enable low run of bad length");
  frame_quiet_a: assert property (@(posedge interface_receive_clock)
    disable iff (!aresetn)
    !converter_receive_enable_out |-> !converter_serial_out)
    else $error("serial out active in frame");
  stop_convert_a: assert property (@(posedge interface_receive_clock)
    disable iff (!aresetn)
    req_gone |-> ##[0:20] converter_receive_enable_out)
    else $error("conversions continue without request");
endmodule

bind afersi_top afersi_sva afersi_sva_i (.*);

/* File: verif/afersi_adc_model.sv */
// Behavioural serial converter on the far side of the link
module afersi_adc_model (
  input  wire logic        sclk,
  input  wire logic        enable_n,
  input  wire logic [15:0] word,
  output logic             sdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] idx = 4'h0;
  initial sdata = 1'b0;
  // Frame bits MSB first; released line toggles
  always @(negedge sclk) begin
    if (!enable_n) begin
      sdata <= word[~idx];
      idx   <= idx + 4'h1;
    end else begin
      sdata <= ~sdata;
      idx   <= 4'h0;
    end
  end
endmodule

/* File: verif/test_afe_rx_serial_adc_interface.sv */
// Self-checking bench for the receive converter interface
`define CHK(n, e, g) cmp(n, 32'(e), 32'(g))
module test_afe_rx_serial_adc_interface;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 1'b0, aresetn = 1'b0, interface_receive_clock = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d, v;
  logic [3:0]  wstrb = 4'hf;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, phy_receive_request = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, cap_arm = 1'b0;
  logic        converter_serial_in, converter_serial_out;
  logic        converter_receive_enable_out;
  logic [1:0]  bresp, rresp, r;
  logic [15:0] adc_word = 16'h0, cap = 16'h0;
  logic [7:0]  prev;
  int          num_errors = 0, checked = 0, low_n = 0, last_run = 0;
  int          cap_n = 0, k, c, len, pos;
  int unsigned seed;

  afersi_top afersi_top_i (.aclk, .aresetn, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .interface_receive_clock, .phy_receive_request, .converter_serial_in,
    .converter_serial_out, .converter_receive_enable_out);
  afersi_adc_model afersi_adc_model_i (.sclk(interface_receive_clock),
    .enable_n(converter_receive_enable_out), .word(adc_word),
    .sdata(converter_serial_in));

  always #20 aclk = ~aclk;
  initial begin
    #13;
    forever #40 interface_receive_clock = ~interface_receive_clock;
  end

  // ====================
  // Link monitor: low runs and config bits
  always @(posedge interface_receive_clock) begin
    if (!converter_receive_enable_out) begin
      low_n <= low_n + 1;
    end else if (low_n != 0) begin
      last_run <= low_n;
      low_n <= 0;
    end
    if (!cap_arm) begin
      cap_n <= 0;
    end else if (cap_n < 16 && (cap_n != 0 || converter_serial_out)) begin
      cap <= {cap[14:0], converter_serial_out};
      cap_n <= cap_n + 1;
    end
  end

  // ====================
  // Helpers
  task automatic test_done;
    $display("Checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic cmp(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic expired(input int i);
    if (i >= 50) begin
      num_errors++;
      $display("Error bus wait expected answer seen none");
      test_done;
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] x);
    int i;
    awaddr <= a;
    wdata <= x;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
    end
    r = bresp;
    expired(i);
  endtask

  task automatic rd(input logic [7:0] a);
    int i;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
    end
    d = rdata;
    r = rresp;
    expired(i);
  endtask

  function automatic logic [7:0] exp_res(logic [15:0] w, int n, int p);
    logic [7:0] res;
    res = 8'h00;
    for (int i = 15; i >= 0; i--) begin
      if (i < p || i >= p + n) res = {res[6:0], w[i]};
    end
    return res;
  endfunction

  // ====================
  // Main sequence
  initial begin
    seed = $urandom(48);
    wt(8);
    aresetn <= 1'b1;
    wt(1);
    for (k = 0; k < 5; k++) begin
      rd(8'(k * 4));
      `CHK("reset value", 0, d);
      `CHK("read resp", k == 4 ? 2'h2 : 2'h0, r);
    end
    wr(8'h10, $urandom);
    `CHK("write resp", afersi_pkg::RESP_SLVERR, r);
    for (k = 0; k < 4; k++) begin
      v = $urandom;
      wr(k % 2 ? afersi_pkg::ADDR_CFG_WORD : afersi_pkg::ADDR_TX_CTRL0, v);
      rd(k % 2 ? afersi_pkg::ADDR_CFG_WORD : afersi_pkg::ADDR_TX_CTRL0);
      `CHK("reg readback", v[15:0], d);
    end
    wr(afersi_pkg::ADDR_TX_CTRL0, 32'h0000a5a5);
    aresetn <= 1'b0;
    wt(8);
    aresetn <= 1'b1;
    wt(1);
    rd(afersi_pkg::ADDR_TX_CTRL0);
    `CHK("reset clears", afersi_pkg::TX_CTRL0_RESET, d);
    $display("registers test done");
    for (c = 0; c < 4; c++) begin
      len = 8 + 2 * c;
      pos = $urandom_range(16 - len);
      adc_word <= 16'($urandom);
      wr(afersi_pkg::ADDR_RX_CTRL, 32'(c | pos << 2));
      phy_receive_request <= 1'b1;
      wr(afersi_pkg::ADDR_IFACE_CTRL, 32'h1);
      wt(150);
      if (c % 2) phy_receive_request <= 1'b0;
      else wr(afersi_pkg::ADDR_IFACE_CTRL, 32'h0);
      wt(60);
      `CHK("stopped", 1, converter_receive_enable_out);
      `CHK("back to back", 1, last_run % 16 == 0 && last_run >= 32);
      rd(afersi_pkg::ADDR_RX_CTRL);
      `CHK("residual", exp_res(adc_word, len, pos), d[15:8]);
      phy_receive_request <= 1'b0;
      wr(afersi_pkg::ADDR_IFACE_CTRL, 32'h0);
    end
    $display("conversion test done");
    prev = d[15:8];
    adc_word <= ~adc_word;
    wr(afersi_pkg::ADDR_IFACE_CTRL, 32'h08);
    for (k = 0; k < 20; k++) begin
      rd(afersi_pkg::ADDR_IFACE_CTRL);
      if (d[4:3] == afersi_pkg::MODE_NORMAL) break;
    end
    `CHK("mode rewritten", afersi_pkg::MODE_NORMAL, d[4:3]);
    wt(40);
    `CHK("wake cycles", afersi_pkg::PD_WAKE_CYCLES, last_run);
    `CHK("back disabled", 1, converter_receive_enable_out);
    rd(afersi_pkg::ADDR_RX_CTRL);
    `CHK("residual kept", prev, d[15:8]);
    $display("power-down test done");
    v = $urandom | 32'h8000;
    wr(afersi_pkg::ADDR_CFG_WORD, v);
    cap_arm <= 1'b1;
    wr(afersi_pkg::ADDR_IFACE_CTRL, 32'h10);
    wt(60);
    `CHK("config word out", v[15:0], cap);
    cap_arm <= 1'b0;
    phy_receive_request <= 1'b1;
    wr(afersi_pkg::ADDR_IFACE_CTRL, 32'h19);
    wt(60);
    `CHK("reserved idle", 1, converter_receive_enable_out);
    `CHK("no frame", afersi_pkg::PD_WAKE_CYCLES, last_run);
    $display("mode test done");
    test_done;
  end
endmodule
